// ===== src/agu_defs.vh
`ifndef AGU_DEFS_VH
`define AGU_DEFS_VH

// Register byte offsets
`define AGU_OFS_MODE_REG 4'h0
`define AGU_OFS_LAST_ADDR 4'h4
`define AGU_OFS_CIRC_COUNT 4'h8
`define AGU_OFS_OP_COUNT 4'hC

// Mode register reset value and fields
`define AGU_MODE_RESET 32'h00000000
`define AGU_SEL_WIDTH 2
`define AGU_BLK0_LSB 16
`define AGU_BLK1_LSB 21
`define AGU_BLK_WIDTH 5
`define AGU_MODE_USED_MASK 32'h03FFFFFF

// Per-register selector encodings
`define AGU_SEL_LINEAR 2'h0
`define AGU_SEL_CIRC_BLK0 2'h1
`define AGU_SEL_CIRC_BLK1 2'h2
`define AGU_SEL_RESERVED 2'h3

// Mode field bit positions
`define AGU_MF_UPDATE 3
`define AGU_MF_REG_OFS 2
`define AGU_MF_POST 1
`define AGU_MF_PLUS 0

// Access sizes (shift amounts)
`define AGU_SIZE_BYTE 2'h0
`define AGU_SIZE_HALF 2'h1
`define AGU_SIZE_WORD 2'h2
`define AGU_SIZE_DOUBLE 2'h3

// Operation kinds
`define AGU_OP_MEMORY 1'b0
`define AGU_OP_ARITH 1'b1

// Register numbers of interest
`define AGU_CIRC_FIRST 4'h4
`define AGU_CIRC_LAST 4'h7
`define AGU_LONG_BASE_LOW 4'hE
`define AGU_LONG_BASE_HIGH 4'hF

`endif

// ===== src/offset_scaler.v
`timescale 1ns/1ps
module offset_scaler (
  // Operand
  input wire [31:0] offset,
  input wire [1:0] size,
  // Result
  output reg [31:0] scaled
);
`include "agu_defs.vh"

  always @* begin
    case (size)
      `AGU_SIZE_BYTE: scaled = offset;
      `AGU_SIZE_HALF: scaled = {offset[30:0], 1'b0};
      `AGU_SIZE_WORD: scaled = {offset[29:0], 2'h0};
      `AGU_SIZE_DOUBLE: scaled = {offset[28:0], 3'h0};
      default: scaled = offset;
    endcase
  end
endmodule // offset_scaler

// ===== src/circular_window.v
`timescale 1ns/1ps
module circular_window (
  // Operands
  input wire [31:0] base,
  input wire [31:0] sum,
  input wire circ_en,
  input wire [4:0] blk_n,
  // Result
  output wire [31:0] result
);

  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : g_bit
      // With circ_en set, bit i follows the sum only inside the window of 2^(N+1) bytes
      wire in_window;
      assign in_window = ~circ_en | (i <= blk_n);
      assign result[i] = in_window ? sum[i] : base[i];
    end
  endgenerate
endmodule // circular_window

// ===== src/load_store_address_generator.v
// Contract
// - Three kinds: linear, circular with block field zero, circular with block field one.
// - Any base register may use linear calculation.
// - Circular only for file A 4-7 on side A, file B 4-7 on side B.
// - Memory ops and scaled add/subtract consult the mode register for those eight.
// - Memory offset shifted by 3, 2, 1, 0 by size, then added or subtracted.
// - Pre and plain offset options access the newly computed address.
// - Post options access the base value before the update.
// - Scaled add/subtract shift the source by size, then add or subtract.
// - Circular results update only bits N..0; upper bits keep the base.
// - Circular result stays in a 2^(N+1)-byte window, offset wraps.
// - Block size is in bytes, never scaled by access size.
// - Block field value N gives a buffer of 2^(N+1) bytes.
// - Long base registers take a 15-bit unsigned offset, positive, no update.
// - Ordinary form: base plus register or 5-bit unsigned constant offset.
// - Pre and post options write back the base; plain offsets do not.
// - Mode field: update, register offset, post, plus from top bit down.
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module load_store_address_generator (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Avalon-MM register slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Request from decode stage and register file
  input wire op_valid,
  input wire op_kind,
  input wire unit_side_b,
  input wire [3:0] base_index,
  input wire [31:0] base_register_operand,
  input wire [31:0] offset_register_operand,
  input wire [4:0] short_unsigned_offset,
  input wire [14:0] long_unsigned_offset,
  input wire long_form,
  input wire [3:0] mode_field,
  input wire [1:0] access_size,
  input wire arith_use_register,
  input wire arith_plus,
  // Result toward memory access path and register file
  output reg result_valid,
  output reg [31:0] mem_address,
  output reg mem_access,
  output reg [31:0] arith_result,
  output reg arith_done,
  output reg base_write_enable,
  output reg [3:0] base_write_index,
  output reg base_write_side_b,
  output reg [31:0] base_write_value,
  output reg circular_used
);
`include "agu_defs.vh"

  reg [31:0] addressing_mode_register;
  reg [31:0] last_addr;
  reg [31:0] circ_count;
  reg [31:0] op_count;
  reg bus_ack;

  // ---------------- Register bus ----------------
  // Every access stalls exactly one cycle so read data can come from a flop
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;

  wire bus_write_now = avs_write & bus_ack;
  wire [31:0] byte_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  reg [31:0] next_readdata;
  always @* begin
    case (avs_address)
      `AGU_OFS_MODE_REG: next_readdata = addressing_mode_register;
      `AGU_OFS_LAST_ADDR: next_readdata = last_addr;
      `AGU_OFS_CIRC_COUNT: next_readdata = circ_count;
      `AGU_OFS_OP_COUNT: next_readdata = op_count;
      default: next_readdata = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_ack <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      bus_ack <= (avs_read | avs_write) & ~bus_ack;
      if (avs_read & ~bus_ack) begin
        avs_readdata <= next_readdata;
      end
    end
  end

  // Unused upper bits of the mode register are held at zero
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addressing_mode_register <= `AGU_MODE_RESET;
    end else if (bus_write_now && avs_address == `AGU_OFS_MODE_REG) begin
      addressing_mode_register <= ((addressing_mode_register & ~byte_mask) |
                                   (avs_writedata & byte_mask)) & `AGU_MODE_USED_MASK;
    end
  end

  // ---------------- Mode selection ----------------
  // Only registers 4..7 of the unit's own file may go circular
  wire circ_capable = (base_index >= `AGU_CIRC_FIRST) &&
                      (base_index <= `AGU_CIRC_LAST);
  wire is_long_base = unit_side_b && ((base_index == `AGU_LONG_BASE_LOW) ||
                                      (base_index == `AGU_LONG_BASE_HIGH));
  wire use_long = long_form & is_long_base & (op_kind == `AGU_OP_MEMORY);

  wire [2:0] sel_slot = {unit_side_b, base_index[1:0]};
  wire [`AGU_SEL_WIDTH-1:0] selector =
    addressing_mode_register[sel_slot*`AGU_SEL_WIDTH +: `AGU_SEL_WIDTH];

  wire [4:0] blk0 = addressing_mode_register[`AGU_BLK0_LSB +: `AGU_BLK_WIDTH];
  wire [4:0] blk1 = addressing_mode_register[`AGU_BLK1_LSB +: `AGU_BLK_WIDTH];

  reg circ_en;
  reg [4:0] blk_n;
  always @* begin
    circ_en = 1'b0;
    blk_n = 5'h00;
    if (circ_capable && !use_long) begin
      case (selector)
        `AGU_SEL_CIRC_BLK0: begin
          circ_en = 1'b1;
          blk_n = blk0;
        end
        `AGU_SEL_CIRC_BLK1: begin
          circ_en = 1'b1;
          blk_n = blk1;
        end
        // Reserved encoding falls back to linear so an odd value cannot trap
        default: begin
          circ_en = 1'b0;
          blk_n = 5'h00;
        end
      endcase
    end
  end

  // ---------------- Offset and direction ----------------
  wire mf_update = mode_field[`AGU_MF_UPDATE];
  wire mf_reg_ofs = mode_field[`AGU_MF_REG_OFS];
  wire mf_post = mode_field[`AGU_MF_POST] & mf_update;
  wire mf_plus = mode_field[`AGU_MF_PLUS];

  reg [31:0] raw_offset;
  reg add_dir;
  always @* begin
    if (op_kind == `AGU_OP_ARITH) begin
      raw_offset = arith_use_register ? offset_register_operand
                                      : {27'h0, short_unsigned_offset};
      add_dir = arith_plus;
    end else if (use_long) begin
      raw_offset = {17'h0, long_unsigned_offset};
      add_dir = 1'b1;
    end else begin
      raw_offset = mf_reg_ofs ? offset_register_operand
                              : {27'h0, short_unsigned_offset};
      add_dir = mf_plus;
    end
  end

  wire [31:0] scaled_offset;
  offset_scaler u_scaler (
    .offset(raw_offset),
    .size(access_size),
    .scaled(scaled_offset)
  );

  wire [31:0] raw_sum = add_dir ? base_register_operand + scaled_offset
                                : base_register_operand - scaled_offset;

  // Block size is a byte count, so the window ignores access size
  wire [31:0] new_address;
  circular_window u_window (
    .base(base_register_operand),
    .sum(raw_sum),
    .circ_en(circ_en),
    .blk_n(blk_n),
    .result(new_address)
  );

  wire mem_op = (op_kind == `AGU_OP_MEMORY);
  wire do_update = mem_op & mf_update & ~use_long;
  wire [31:0] access_addr = mf_post && !use_long ? base_register_operand
                                                 : new_address;

  // ---------------- Result stage ----------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result_valid <= 1'b0;
      mem_access <= 1'b0;
      arith_done <= 1'b0;
      mem_address <= 32'h00000000;
      arith_result <= 32'h00000000;
      base_write_enable <= 1'b0;
      base_write_index <= 4'h0;
      base_write_side_b <= 1'b0;
      base_write_value <= 32'h00000000;
      circular_used <= 1'b0;
    end else begin
      result_valid <= op_valid;
      mem_access <= op_valid & mem_op;
      arith_done <= op_valid & ~mem_op;
      base_write_enable <= op_valid & do_update;
      circular_used <= op_valid & circ_en;
      if (op_valid) begin
        base_write_index <= base_index;
        base_write_side_b <= unit_side_b;
        base_write_value <= new_address;
        if (mem_op) begin
          mem_address <= access_addr;
        end else begin
          arith_result <= new_address;
        end
      end
    end
  end

  // ---------------- Status counters ----------------
  // Counters wrap; software reads differences rather than absolute values
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_addr <= 32'h00000000;
      circ_count <= 32'h00000000;
      op_count <= 32'h00000000;
    end else if (op_valid) begin
      last_addr <= mem_op ? access_addr : new_address;
      op_count <= op_count + 32'h00000001;
      if (circ_en) begin
        circ_count <= circ_count + 32'h00000001;
      end
    end
  end
endmodule // load_store_address_generator

// ===== dv/agu_chk_sva.sv
`timescale 1ns/1ps
module agu_chk (
  // Watched ports
  input wire clk, rst_b, avs_read, avs_write, avs_waitrequest, op_valid, op_kind, long_form,
  input wire [3:0] base_index, mode_field,
  input wire [31:0] base_register_operand, mem_address, base_write_value,
  input wire result_valid, mem_access, arith_done, base_write_enable, circular_used
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire mem = op_valid && !op_kind && !long_form;
  property p_lat; 1 |=> result_valid == $past(op_valid); endproperty
  a_lat: assert property (p_lat) else $error("result pulse wrong");
  property p_kind; op_valid && !op_kind |=> mem_access && !arith_done; endproperty
  a_kind: assert property (p_kind) else $error("memory result missing");
  property p_arith; op_valid && op_kind |=> arith_done && !base_write_enable; endproperty
  a_arith: assert property (p_arith) else $error("arith result wrong");
  property p_post;
    mem && mode_field[3] && mode_field[1] |=> mem_address == $past(base_register_operand);
  endproperty
  a_post: assert property (p_post) else $error("post access not at base");
  property p_pre;
    mem && mode_field[3:1] == 3'b100 |=> base_write_enable && mem_address == base_write_value;
  endproperty
  a_pre: assert property (p_pre) else $error("pre access not at new address");
  property p_nowb; op_valid && !op_kind && !mode_field[3] |=> !base_write_enable; endproperty
  a_nowb: assert property (p_nowb) else $error("plain offset wrote base");
  property p_circ; op_valid && base_index[3:2] != 2'b01 |=> !circular_used; endproperty
  a_circ: assert property (p_circ) else $error("circular on wrong register");
  property p_bus; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_bus: assert property (p_bus) else $error("bus answer late");
  c_circ: cover property (circular_used && mem_access);
  c_post: cover property (mem && mode_field[3] && mode_field[1]);
  c_wr: cover property (avs_write && !avs_waitrequest);
endmodule // agu_chk
bind load_store_address_generator agu_chk i_agu_chk (.clk, .rst_b, .avs_read, .avs_write,
  .avs_waitrequest, .op_valid, .op_kind, .long_form, .base_index, .mode_field,
  .base_register_operand, .mem_address, .base_write_value, .result_valid, .mem_access,
  .arith_done, .base_write_enable, .circular_used);

// ===== dv/op_source.sv
`timescale 1ns/1ps
module op_source (
  // Clock
  input wire logic clk,
  // Operation toward the generator
  output logic op_valid, op_kind, unit_side_b, long_form, arith_use_register, arith_plus,
  output logic [3:0] base_index, mode_field,
  output logic [31:0] base_register_operand, offset_register_operand,
  output logic [4:0] short_unsigned_offset,
  output logic [14:0] long_unsigned_offset,
  output logic [1:0] access_size
);
  initial {op_valid, op_kind, unit_side_b, long_form, arith_use_register, arith_plus,
    base_index, mode_field, base_register_operand, offset_register_operand,
    short_unsigned_offset, long_unsigned_offset, access_size} = '0;
  task issue(input logic k, sb, lf, input logic [3:0] idx, mf, input logic [31:0] b, o,
    input logic [1:0] sz);
    @(posedge clk);
    op_valid <= 1'b1;
    op_kind <= k;
    unit_side_b <= sb;
    long_form <= lf;
    base_index <= idx;
    mode_field <= mf;
    base_register_operand <= b;
    offset_register_operand <= o;
    short_unsigned_offset <= o[4:0];
    long_unsigned_offset <= o[14:0];
    access_size <= sz;
    arith_use_register <= mf[2];
    arith_plus <= mf[0];
    @(posedge clk);
    op_valid <= 1'b0;
    // Stale operands must not look valid once the pulse is gone
    base_register_operand <= ~b;
    offset_register_operand <= ~o;
  endtask
endmodule // op_source

// ===== dv/load_store_address_generator_tb_top.sv
`timescale 1ns/1ps
module load_store_address_generator_tb_top;
  logic clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF, base_index, mode_field, base_write_index;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, mem_address, arith_result, base_write_value;
  logic avs_waitrequest, result_valid, mem_access, arith_done, base_write_enable;
  logic base_write_side_b, circular_used, op_valid, op_kind, unit_side_b, long_form;
  logic arith_use_register, arith_plus;
  logic [31:0] base_register_operand, offset_register_operand, q, e, n;
  logic [4:0] short_unsigned_offset;
  logic [14:0] long_unsigned_offset;
  logic [1:0] access_size;
  int failures = 0, num_checks = 0;
  always #25 clk = ~clk;
  op_source i_op_source (.clk, .op_valid, .op_kind, .unit_side_b, .long_form,
    .arith_use_register, .arith_plus, .base_index, .mode_field, .base_register_operand,
    .offset_register_operand, .short_unsigned_offset, .long_unsigned_offset, .access_size);
  load_store_address_generator i_load_store_address_generator (.clk, .rst_b, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .op_valid, .op_kind, .unit_side_b, .base_index, .base_register_operand,
    .offset_register_operand, .short_unsigned_offset, .long_unsigned_offset, .long_form,
    .mode_field, .access_size, .arith_use_register, .arith_plus, .result_valid, .mem_address,
    .mem_access, .arith_result, .arith_done, .base_write_enable, .base_write_index,
    .base_write_side_b, .base_write_value, .circular_used);
  task close_out;
    $display("Checks made %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (k >= 20) begin
      failures++;
      close_out;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Result lands at the edge that takes the request; look just after it
  task op(input logic k, sb, lf, input logic [3:0] idx, mf, input logic [31:0] b, o,
    input logic [1:0] sz, input logic [31:0] ea, input logic we, input logic [31:0] wv,
    input logic c);
    i_op_source.issue(k, sb, lf, idx, mf, b, o, sz);
    #1;
    chk(k ? arith_result : mem_address, ea);
    chk({31'h0, base_write_enable}, {31'h0, we});
    chk({31'h0, circular_used}, {31'h0, c});
    if (we) chk(base_write_value, wv);
    if (we) chk({27'h0, base_write_side_b, base_write_index}, {27'h0, sb, idx});
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    bus(0, 4'h0, 0);
    chk(q, 32'h0);
    bus(0, 4'h2, 0);
    chk(q, 32'h0);
    bus(1, 4'h0, 32'hFC040001);
    bus(0, 4'h0, 0);
    chk(q, 32'h00040001);
    for (int m = 0; m < 16; m++) begin
      e = m[2] ? 32'h25 : 32'h5;
      n = m[0] ? 32'h1000 + (e << 2) : 32'h1000 - (e << 2);
      op(0, 0, 0, 4'h5, m[3:0], 32'h1000, 32'h25, 2'h2, (m[3] && m[1]) ? 32'h1000 : n,
        m[3], n, 0);
    end
    for (int s = 0; s < 4; s++) begin
      op(0, 0, 0, 4'h8, 4'h5, 32'h1000, 32'h3, s[1:0], 32'h1000 + (32'h3 << s), 0, 0, 0);
    end
    op(0, 0, 0, 4'h4, 4'h9, 32'h100, 32'h9, 2'h2, 32'h104, 1, 32'h104, 1);
    op(0, 0, 0, 4'h4, 4'hB, 32'h100, 32'h9, 2'h2, 32'h100, 1, 32'h104, 1);
    op(1, 0, 0, 4'h4, 4'h1, 32'h100, 32'h13, 2'h1, 32'h106, 0, 0, 1);
    op(1, 0, 0, 4'h4, 4'h4, 32'h100, 32'h3, 2'h0, 32'h11D, 0, 0, 1);
    op(0, 1, 0, 4'h4, 4'h9, 32'h100, 32'h9, 2'h2, 32'h124, 1, 32'h124, 0);
    op(0, 0, 0, 4'h8, 4'h9, 32'h100, 32'h9, 2'h2, 32'h124, 1, 32'h124, 0);
    bus(1, 4'h0, 32'h004000E0);
    op(0, 0, 0, 4'h6, 4'h9, 32'h200, 32'h3, 2'h2, 32'h204, 1, 32'h204, 1);
    op(0, 0, 0, 4'h7, 4'h9, 32'h100, 32'h9, 2'h2, 32'h124, 1, 32'h124, 0);
    op(0, 1, 1, 4'hE, 4'hC, 32'h1000, 32'h7FFF, 2'h2, 32'h20FFC, 0, 0, 0);
    op(0, 0, 1, 4'hE, 4'hC, 32'h1000, 32'h7FFF, 2'h2, 32'hFFFE1004, 1, 32'hFFFE1004, 0);
    // Status registers: last address, circular count, operation count
    bus(0, 4'h4, 0);
    chk(q, 32'hFFFE1004);
    bus(0, 4'h8, 0);
    chk(q, 32'h00000005);
    bus(0, 4'hC, 0);
    chk(q, 32'h0000001E);
    // Only lane 1 of the mode register may change
    avs_byteenable <= 4'h2;
    bus(1, 4'h0, 32'hFFFFFFFF);
    avs_byteenable <= 4'hF;
    bus(0, 4'h0, 0);
    chk(q, 32'h0040FFE0);
    close_out;
  end
endmodule // load_store_address_generator_tb_top
